// [rtl/afpr_pkg.sv]
package afpr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FLAG_W = 24;
  localparam int unsigned NCH    = 4;

  // Register offsets as printed
  localparam logic [ADDR_W-1:0] OFF_CAUSE  = 8'h26;
  localparam logic [ADDR_W-1:0] OFF_ROUTE  = 8'h27;
  // Offsets chosen for the control and interrupt registers
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h31;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 8'h32;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MK = 8'h33;

  // Field positions, shared by status, routing and enable
  localparam int unsigned BIT_OC_LO = 20;
  localparam int unsigned BIT_UC_LO = 16;
  localparam int unsigned BIT_OV_LO = 12;
  localparam int unsigned BIT_UV_LO = 8;
  localparam int unsigned BIT_OP_LO = 4;
  localparam int unsigned BIT_ACC   = 3;
  localparam int unsigned BIT_CNT   = 2;
  localparam int unsigned BIT_CC    = 1;

  // Implemented bits of each register
  localparam logic [FLAG_W-1:0] CAUSE_MASK = 24'hFFFFFC;
  localparam logic [FLAG_W-1:0] ROUTE_MASK = 24'hFFFFFE;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 24'h000000;
  localparam logic [FLAG_W-1:0] ROUTE_RESET = 24'h000000;
  localparam logic [FLAG_W-1:0] ENABLE_RESET = 24'h000000;

  // Control register fields
  localparam int unsigned CTRL_PIN_ALERT = 0;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;

  // Interrupt events
  localparam int unsigned IRQ_W       = 2;
  localparam int unsigned IRQ_TRIP    = 0;
  localparam int unsigned IRQ_CONV    = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // Read phase of the cause register clear
  typedef enum logic [1:0] {
    AFPR_IDLE    = 2'b00,
    AFPR_ARMED   = 2'b01
  } afpr_clr_t;

  // Alert source conditions from the limit and accumulator logic
  typedef struct packed {
    logic [NCH-1:0] overcurrent;
    logic [NCH-1:0] undercurrent;
    logic [NCH-1:0] overvoltage;
    logic [NCH-1:0] undervoltage;
    logic [NCH-1:0] overpower;
    logic           accumulator_full;
    logic           sample_counter_full;
    logic           coulomb_count;
    logic           spare;
  } afpr_cond_t;

  // Register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } afpr_req_t;

endpackage

// [rtl/afpr_regbank.sv]
`timescale 1ns/1ps
// Holds the software-written words: routing, enable, control, mask
module afpr_regbank
  import afpr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [FLAG_W-1:0] route_q,
  output logic      [FLAG_W-1:0] enable_q,
  output logic      [1:0]        ctrl_q,
  output logic      [IRQ_W-1:0]  mask_q
);

  logic [FLAG_W-1:0] route_d;
  logic [FLAG_W-1:0] enable_d;
  logic [1:0]        ctrl_d;
  logic [IRQ_W-1:0]  mask_d;

  always_comb begin
    route_d  = route_q;
    enable_d = enable_q;
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    if (wr) begin
      case (addr)
        OFF_ROUTE:  route_d  = wdata[FLAG_W-1:0] & ROUTE_MASK; // RULE8
        OFF_ENABLE: enable_d = wdata[FLAG_W-1:0] & ROUTE_MASK;
        OFF_CTRL:   ctrl_d   = wdata[1:0];
        OFF_IRQ_MK: mask_d   = wdata[IRQ_W-1:0];
        default:    route_d  = route_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      route_q  <= ROUTE_RESET; // RULE8
      enable_q <= ENABLE_RESET; // RULE16
      ctrl_q   <= CTRL_RESET;
      mask_q   <= IRQ_RESET;
    end else begin
      route_q  <= route_d;
      enable_q <= enable_d;
      ctrl_q   <= ctrl_d;
      mask_q   <= mask_d;
    end
  end

endmodule // afpr_regbank

// [rtl/afpr_top.sv]
`timescale 1ns/1ps
// Function
// RULE1: Overvoltage flags of channels 1 to 4 sit at status bits 15 to 12.
// RULE2: Undervoltage flags of channels 1 to 4 sit at status bits 11 to 8.
// RULE3: Overpower flags of channels 1 to 4 sit at status bits 7 to 4.
// RULE4: Status bit 3 flags any accumulator overflow or fullness limit exceeded.
// RULE5: Status bit 2 flags sample counter overflow or fullness limit exceeded.
// RULE6: Status bits 1 and 0 always read as zero.
// RULE7: Routing bits set to one steer their source onto the alert pin.
// RULE8: Routing register is 24 bits, writable, zero at reset, bit 0 unused.
// RULE9: Routing drives the pin only while the pin selects alert function.
// RULE10: Host enables a source before routing it; disabled sources never reach pin. A cause flag latched before disabling still drives the pin.
// RULE11: Host should disable alerts while changing limit values.
// RULE12: Routing bit 15 steers channel 1 overvoltage onto the pin.
// RULE13: Routing bits 23 to 20 steer channels 1 to 4 overcurrent.
// RULE14: Read flags clear after the next conversion unless the cause persists.
// RULE15: Overcurrent flags at bits 23 to 20, undercurrent at 19 to 16.
// RULE16: All limit alerts stay disabled after reset until the host enables them.
// RULE17: Pin is the OR of every tripped and routed source.
module afpr_top
  import afpr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire afpr_cond_t        cond,
  input  wire logic              conv_done,
  output logic                   shared_alert_pin,
  output logic                   irq
);

  logic [FLAG_W-1:0] route_q;
  logic [FLAG_W-1:0] enable_q;
  logic [1:0]        ctrl_q;
  logic [IRQ_W-1:0]  mask_q;

  afpr_regbank u_regs (
    .clk      (clk),
    .rst      (rst),
    .wr       (wr),
    .addr     (addr),
    .wdata    (wdata),
    .route_q  (route_q),
    .enable_q (enable_q),
    .ctrl_q   (ctrl_q),
    .mask_q   (mask_q)
  );

  // Flatten the source conditions into the status layout
  function automatic logic [FLAG_W-1:0] afpr_layout(input afpr_cond_t c);
    logic [FLAG_W-1:0] v;
    v = '0;
    for (int i = 0; i < NCH; i++) begin
      v[BIT_OC_LO + NCH - 1 - i] = c.overcurrent[i]; // RULE15
      v[BIT_UC_LO + NCH - 1 - i] = c.undercurrent[i]; // RULE15
      v[BIT_OV_LO + NCH - 1 - i] = c.overvoltage[i]; // RULE1
      v[BIT_UV_LO + NCH - 1 - i] = c.undervoltage[i]; // RULE2
      v[BIT_OP_LO + NCH - 1 - i] = c.overpower[i]; // RULE3
    end
    v[BIT_ACC] = c.accumulator_full; // RULE4
    v[BIT_CNT] = c.sample_counter_full; // RULE5
    v[BIT_CC]  = c.coulomb_count;
    return v;
  endfunction

  logic [FLAG_W-1:0] live;
  logic [FLAG_W-1:0] gated;
  assign live  = afpr_layout(cond);
  assign gated = live & enable_q; // RULE10 RULE16

  // Cause flags and the read-then-conversion clear
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  afpr_clr_t         clr_q;
  afpr_clr_t         clr_d;
  logic              cause_rd;
  assign cause_rd = rd && (addr == OFF_CAUSE);

  always_comb begin
    flags_d = flags_q;
    clr_d   = clr_q;
    case (clr_q)
      AFPR_IDLE: begin
        if (cause_rd) begin
          clr_d = AFPR_ARMED;
        end
      end
      AFPR_ARMED: begin
        if (conv_done) begin
          clr_d = cause_rd ? AFPR_ARMED : AFPR_IDLE;
        end
      end
      default: clr_d = AFPR_IDLE;
    endcase
    if (conv_done) begin
      if (clr_q == AFPR_ARMED) begin
        flags_d = gated & CAUSE_MASK; // RULE14
      end else begin
        flags_d = (flags_q | gated) & CAUSE_MASK; // RULE6
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= FLAG_RESET;
      clr_q   <= AFPR_IDLE;
    end else begin
      flags_q <= flags_d;
      clr_q   <= clr_d;
    end
  end

  // Pin: tripped and routed sources, only in alert function
  logic pin_d;
  logic [FLAG_W-1:0] pin_src;
  assign pin_src = flags_q | (gated & ROUTE_MASK); // RULE7
  always_comb begin
    pin_d = 1'b0;
    if (ctrl_q[CTRL_PIN_ALERT]) begin // RULE9
      pin_d = |(pin_src & route_q & ROUTE_MASK); // RULE7 RULE12 RULE13 RULE17
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  logic [IRQ_W-1:0] ist_q;
  logic [IRQ_W-1:0] ist_d;
  logic [IRQ_W-1:0] ev;
  logic             irq_d;
  always_comb begin
    ev = '0;
    ev[IRQ_TRIP] = conv_done && (|(gated & CAUSE_MASK));
    ev[IRQ_CONV] = conv_done;
    ist_d = ist_q;
    if (wr && (addr == OFF_IRQ_ST)) begin
      ist_d = ist_q & ~wdata[IRQ_W-1:0];
    end
    ist_d = ist_d | ev;
    irq_d = |(ist_d & mask_q);
  end

  // Read port
  logic [DATA_W-1:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    if (rd) begin
      case (addr)
        OFF_CAUSE:  rdata_d[FLAG_W-1:0] = flags_q & CAUSE_MASK; // RULE6
        OFF_ROUTE:  rdata_d[FLAG_W-1:0] = route_q; // RULE8
        OFF_ENABLE: rdata_d[FLAG_W-1:0] = enable_q;
        OFF_CTRL:   rdata_d[1:0]        = ctrl_q;
        OFF_IRQ_ST: rdata_d[IRQ_W-1:0]  = ist_q;
        OFF_IRQ_MK: rdata_d[IRQ_W-1:0]  = mask_q;
        default:    rdata_d             = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata            <= '0;
      shared_alert_pin <= 1'b0;
      ist_q            <= IRQ_RESET;
      irq              <= 1'b0;
    end else begin
      rdata            <= rdata_d;
      shared_alert_pin <= pin_d;
      ist_q            <= ist_d;
      irq              <= irq_d;
    end
  end

endmodule // afpr_top

// [dv/afpr_properties.sv]
`timescale 1ns/1ps
module afpr_chk
  import afpr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire afpr_cond_t  cond,
  input wire logic        conv_done,
  input wire logic        shared_alert_pin,
  input wire logic        irq
);
  logic rs_q;
  wire  rc = rd && addr == OFF_CAUSE;
  wire  rr = rd && addr == OFF_ROUTE;
  always_ff @(posedge clk) rs_q <= rst;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  idle_rdata_a: assert property (!(rd && addr inside {[8'h26:8'h27], [8'h30:8'h33]})
    |=> rdata == '0) else $error("rdata not zero");
  cause_spare_a: assert property (rc |=> rdata[1:0] == 2'h0 && rdata[31:24] == 8'h00)
    else $error("cause spare bits set");
  route_back_a: assert property (wr && addr == OFF_ROUTE ##1 rr
    |=> rdata == ($past(wdata, 2) & 32'h00FFFFFE)) else $error("route readback wrong");
  route_spare_a: assert property (rr |=> rdata[0] == 1'h0 && rdata[31:24] == 8'h00)
    else $error("route spare bits set");
  flag_hold_a: assert property (rc && !conv_done ##1 rc |=> rdata == $past(rdata))
    else $error("flags moved without conversion");
  flag_clear_a: assert property (rc && !conv_done ##1 conv_done && cond == '0 && !rd
    ##1 rc |=> rdata == '0) else $error("flags not cleared");
  reset_quiet_a: assert property (rs_q |-> !shared_alert_pin && !irq && rdata == '0)
    else $error("outputs active after reset");
  pin_cause_a: assert property ($rose(shared_alert_pin)
    |-> $past(cond) != '0 || $past(wr) || $past(wr, 2)) else $error("pin rose without cause");
endmodule // afpr_chk

bind afpr_top afpr_chk u_chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cond, .conv_done,
  .shared_alert_pin, .irq);

// [dv/afpr_meter.sv]
`timescale 1ns/1ps
// Front end stand-in: new conditions land with a conversion end
module afpr_meter
  import afpr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire afpr_cond_t nxt,
  output afpr_cond_t      cond = '0,
  output logic            conv_done = 1'h0
);
  always_ff @(posedge clk) begin
    conv_done <= go && !rst;
    if (rst) cond <= '0;
    else if (go) cond <= nxt;
  end
endmodule // afpr_meter

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import afpr_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        go = 1'h0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h000163CD;
  logic [23:0] fl_m = 24'h0, rt_m = 24'h0, en_m = 24'h0;
  logic        arm_m = 1'h0, ctl_m = 1'h0, conv_done, pin, irq;
  afpr_cond_t  nxt = '0, cond;
  int          fail_count = 0, compares = 0;
  always #5 clk = ~clk;
  afpr_meter u_meter (.clk, .rst, .go, .nxt, .cond, .conv_done);
  afpr_top u_dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cond, .conv_done,
    .shared_alert_pin(pin), .irq);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [23:0] lay(afpr_cond_t c);
    logic [23:0] v;
    v = {20'h0, c.accumulator_full, c.sample_counter_full, c.coulomb_count, 1'h0};
    for (int k = 0; k < 4; k++) begin
      v[23 - k] = c.overcurrent[k];
      v[19 - k] = c.undercurrent[k];
      v[15 - k] = c.overvoltage[k];
      v[11 - k] = c.undervoltage[k];
      v[7 - k]  = c.overpower[k];
    end
    return v;
  endfunction
  function automatic logic [31:0] pin_exp();
    return 32'(ctl_m && (|((fl_m | (lay(cond) & en_m)) & rt_m & 24'hFFFFFE)));
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk) wr <= 1'h0;
    #1;
    if (a == OFF_ROUTE) rt_m = d[23:0] & 24'hFFFFFE;
    if (a == OFF_ENABLE) en_m = d[23:0] & 24'hFFFFFE;
    if (a == OFF_CTRL) ctl_m = d[0];
  endtask
  task automatic rreg(logic [7:0] a, output logic [31:0] d);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk) rd <= 1'h0;
    #1 d = rdata;
    if (a == OFF_CAUSE) arm_m = 1'h1;
  endtask
  task automatic conv(afpr_cond_t c);
    go <= 1'h1;
    nxt <= c;
    @(posedge clk) go <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    fl_m = (arm_m ? 24'h0 : fl_m) | (lay(c) & en_m & 24'hFFFFFC);
    arm_m = 1'h0;
  endtask
  task automatic wrap_up();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    logic [31:0] d;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    #1;
    rreg(OFF_CAUSE, d);
    chk(d, 32'h0);
    rreg(8'h10, d);
    chk(d, 32'h0);
    wreg(OFF_ROUTE, 32'hFFFFFFFF);
    rreg(OFF_ROUTE, d);
    chk(d, 32'h00FFFFFE);
    conv('1);
    rreg(OFF_CAUSE, d);
    chk(d, 32'h0);
    wreg(OFF_ENABLE, 32'h00FFFFFF);
    conv('1);
    chk(32'(pin), pin_exp());
    wreg(OFF_CTRL, 32'h1);
    conv('1);
    chk(32'(pin), pin_exp());
    rreg(OFF_CAUSE, d);
    chk(d, {8'h0, fl_m});
    for (int i = 0; i < 24; i++) begin
      wreg(OFF_ROUTE, 32'h1 << i);
      conv(afpr_cond_t'(24'h1 << i));
      chk(32'(pin), pin_exp());
      rreg(OFF_CAUSE, d);
      chk(d, {8'h0, fl_m});
    end
    go <= 1'h1;
    nxt <= '0;
    rreg(OFF_CAUSE, d);
    go <= 1'h0;
    @(posedge clk);
    #1;
    rreg(OFF_CAUSE, d);
    chk(d, 32'h0);
    fl_m = 24'h0;
    repeat (40) begin
      wreg(OFF_ROUTE, rnd());
      conv(afpr_cond_t'(rnd() & rnd() & rnd()));
      chk(32'(pin), pin_exp());
      if (rnd() & 32'h1) begin
        rreg(OFF_CAUSE, d);
        chk(d, {8'h0, fl_m});
        rreg(OFF_CAUSE, d);
        chk(d, {8'h0, fl_m});
      end
    end
    wreg(OFF_IRQ_MK, 32'h1);
    conv(afpr_cond_t'(24'h000100));
    chk(32'(irq), 32'h1);
    wreg(OFF_IRQ_ST, 32'h3);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'h0);
    wreg(OFF_IRQ_MK, 32'h0);
    conv(afpr_cond_t'(24'h000100));
    chk(32'(irq), 32'h0);
    rreg(OFF_IRQ_ST, d);
    chk(d, 32'h3);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule // tb
